// file: blsc_top.sv
// Host service control: forwards bus bytes, indications, ack modes, repeats.
// Assumes decoded one-cycle request pulses and bus event pulses, one clock.
// Functional notes
// - Forward bus bytes; acks only when monitoring
// - Send reset indication on entering normal
// - Set collision and thermal flags on events
// - Set host byte fault on corrupt input
// - Flag sent zero read back one
// - Flag invalid host request order
// - Busy plus auto-ack answers own address BUSY
// - Host ack request clears busy mode
// - Leave busy returns to ACK answers
// - Monitor mode passes all bus data
// - Monitor mode exits only by reset
// - Set address stores it, enables auto-ack
// - Receive error on acked frame gives NACK
// - Repeated set address only updates address
// - Auto-ack activation sends configuration indication
// - Address applies only when bus idle
// - Auto-ack stays until reset request
// - Busy and nack limits reset to three
// - BUSY retry after 150 idle bits
// - NACK retry after 50 idle bits
// - Limit counts retries after first try
// - State indication byte layout
// - Confirmation bit seven gives result
`timescale 1ns/1ps
module blsc_top import blsc_pkg::*; (
	// Clock, reset, enable
	input wire logic i_clk,
	input wire logic i_reset,
	input wire logic i_ce,
	// Host requests, one-cycle pulses
	input wire logic i_host_reset_req,
	input wire logic i_enter_normal,
	input wire logic i_enter_reject_mode_request,
	input wire logic i_leave_reject_mode_request,
	input wire logic i_host_ack_req,
	input wire logic i_monitor_req,
	input wire logic i_set_addr_req,
	input wire logic [15:0] i_set_addr,
	input wire logic i_set_rep_req,
	input wire logic [7:0] i_set_rep_byte,
	input wire logic i_state_req,
	input wire logic i_auto_poll_on,
	input wire logic i_crc_on,
	input wire logic i_marker_on,
	// Error events
	input wire logic i_poll_collision,
	input wire logic i_thermal_warn,
	input wire logic i_host_byte_bad,
	input wire logic i_cmd_order_bad,
	// Bus receive side
	input wire logic i_rx_valid,
	input wire logic [7:0] i_rx_data,
	input wire logic i_rx_is_ack,
	input wire logic i_bus_idle,
	input wire logic i_rx_dest_hit,
	input wire logic [15:0] i_rx_dest,
	input wire logic i_rx_dest_group,
	input wire logic i_rx_error,
	input wire logic i_rx_frame_end,
	// Bus transmit side
	input wire logic i_tx_start,
	input wire logic i_tx_done,
	input wire logic i_tx_drive_zero,
	input wire logic i_tx_read_bit,
	input wire logic i_ack_valid,
	input wire logic [1:0] i_ack_kind,
	output logic o_tx_go,
	// Auto acknowledge
	output logic o_ack_send,
	output logic [1:0] o_ack_kind,
	// Host byte stream
	output logic o_host_valid,
	output logic [7:0] o_host_data,
	input wire logic i_host_ready,
	// Status
	output logic o_monitor_mode,
	output logic o_auto_ack_flag,
	output logic o_reject_mode,
	output logic [15:0] o_phys_addr,
	output logic [2:0] o_busy_limit,
	output logic [2:0] o_nack_limit
);
	logic busy_ff, aa_ff, mon_ff, addr_pend_ff;
	logic [15:0] addr_ff, addr_new_ff;
	logic [2:0] blim_ff, nlim_ff, bcnt_ff, ncnt_ff;
	logic sc_ff, re_ff, te_ff, pe_ff, tw_ff;
	logic rst_pend_ff, cfg_pend_ff, st_pend_ff, con_pend_ff, con_ok_ff;
	logic ack_send_ff;
	logic [1:0] ack_kind_ff;
	blsc_tx_t tx_ff, nxt_tx;
	logic [13:0] bit_ff;
	logic [7:0] gap_ff, gap_need_ff;
	logic go_ff;

	// Event wires; host_rst, aa_on, ack_now, ack_in and ack_tmo gated by the clock enable
	wire host_rst = i_ce && i_host_reset_req;
	wire fwd_rx = i_rx_valid && (!i_rx_is_ack || mon_ff);
	wire apply_addr = addr_pend_ff && i_bus_idle;
	wire aa_on = i_ce && !host_rst && !i_set_addr_req && apply_addr && !aa_ff;
	wire own_hit = i_rx_dest_hit && (i_rx_dest_group || i_rx_dest == addr_ff);
	wire ack_now = i_ce && i_rx_frame_end && aa_ff && own_hit && !mon_ff;
	wire tx_bad = i_tx_drive_zero && i_tx_read_bit;
	wire [7:0] state_byte = {sc_ff, re_ff, te_ff, pe_ff, tw_ff, `BLSC_STATE_LOW};
	wire [7:0] cfg_byte = {1'b0, busy_ff, aa_ff, i_auto_poll_on, i_crc_on, i_marker_on,
		`BLSC_CFG_IND_LOW};
	wire [7:0] con_byte = {con_ok_ff, `BLSC_CON_LOW};
	wire bit_tick = (bit_ff == 14'h0000);
	wire ack_in = i_ce && (tx_ff == BLSC_TX_WAIT) && i_ack_valid;
	wire ack_tmo = i_ce && (tx_ff == BLSC_TX_WAIT) && bit_tick
		&& (gap_ff == 8'(`BLSC_ACK_WAIT_BITS));
	wire is_busy = ack_in && (i_ack_kind == BLSC_ACK_BUSY);
	wire is_iack = ack_in && (i_ack_kind == BLSC_ACK_IACK);
	wire is_nack = (ack_in && !is_busy && !is_iack) || ack_tmo;
	wire retry_busy = is_busy && (bcnt_ff != 3'h0);
	wire retry_nack = is_nack && (ncnt_ff != 3'h0);
	wire finish = is_iack || (is_busy && !retry_busy) || (is_nack && !retry_nack);

	// Host stream source priority: bus byte, reset, config, confirm, state
	logic src_valid;
	logic [7:0] src_data;
	logic src_ready;
	assign src_valid = i_ce && (fwd_rx || rst_pend_ff || cfg_pend_ff || con_pend_ff
		|| st_pend_ff);
	assign src_data = fwd_rx ? i_rx_data : rst_pend_ff ? `BLSC_RESET_IND
		: cfg_pend_ff ? cfg_byte : con_pend_ff ? con_byte : state_byte;
	wire take = src_valid && src_ready;
	wire take_rx = take && fwd_rx;
	wire take_rst = take && !fwd_rx && rst_pend_ff;
	wire take_cfg = take && !fwd_rx && !rst_pend_ff && cfg_pend_ff;
	wire take_con = take && !fwd_rx && !rst_pend_ff && !cfg_pend_ff && con_pend_ff;
	wire take_st = take && !fwd_rx && !rst_pend_ff && !cfg_pend_ff && !con_pend_ff;

	blsc_buf2 u_buf (
		.i_clk(i_clk),
		.i_reset(i_reset),
		.i_ce(i_ce),
		.i_valid(src_valid),
		.i_data(src_data),
		.o_ready(src_ready),
		.o_valid(o_host_valid),
		.o_data(o_host_data),
		.i_ready(i_host_ready)
	);

	// Mode flags: busy, monitor, auto-ack, address
	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			busy_ff <= 1'b0;
			aa_ff <= 1'b0;
			mon_ff <= 1'b0;
			addr_pend_ff <= 1'b0;
			addr_ff <= 16'h0000;
			addr_new_ff <= 16'h0000;
		end else if (host_rst) begin
			busy_ff <= 1'b0;
			aa_ff <= 1'b0;
			mon_ff <= 1'b0;
			addr_pend_ff <= 1'b0;
		end else if (i_ce) begin
			if (i_monitor_req)
				mon_ff <= 1'b1;
			if (i_enter_reject_mode_request && aa_ff)
				busy_ff <= 1'b1;
			else if (i_host_ack_req)
				busy_ff <= 1'b0;
			else if (i_leave_reject_mode_request && aa_ff)
				busy_ff <= 1'b0;
			if (i_set_addr_req) begin
				addr_new_ff <= i_set_addr;
				addr_pend_ff <= 1'b1;
			end else if (apply_addr) begin
				addr_ff <= addr_new_ff;
				aa_ff <= 1'b1;
				addr_pend_ff <= 1'b0;
			end
		end
	end

	// Pending indications to the host; a new cause wins over the take
	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			rst_pend_ff <= 1'b0;
			cfg_pend_ff <= 1'b0;
			st_pend_ff <= 1'b0;
			con_pend_ff <= 1'b0;
			con_ok_ff <= 1'b0;
		end else if (i_ce) begin
			rst_pend_ff <= i_enter_normal || (rst_pend_ff && !take_rst);
			cfg_pend_ff <= aa_on || (cfg_pend_ff && !take_cfg);
			st_pend_ff <= i_state_req || (st_pend_ff && !take_st);
			con_pend_ff <= finish || (con_pend_ff && !take_con);
			if (finish)
				con_ok_ff <= is_iack;
		end
	end

	// Sticky state flags; set wins over clear on state read
	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			sc_ff <= 1'b0;
			re_ff <= 1'b0;
			te_ff <= 1'b0;
			pe_ff <= 1'b0;
			tw_ff <= 1'b0;
		end else if (i_ce) begin
			sc_ff <= i_poll_collision || (sc_ff && !take_st);
			tw_ff <= i_thermal_warn || (tw_ff && !take_st);
			re_ff <= i_host_byte_bad || (re_ff && !take_st);
			te_ff <= (tx_ff == BLSC_TX_SEND && tx_bad) || (te_ff && !take_st);
			pe_ff <= i_cmd_order_bad || (pe_ff && !take_st);
		end
	end

	// Auto acknowledge answer, one pulse at frame end
	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			ack_send_ff <= 1'b0;
			ack_kind_ff <= BLSC_ACK_IACK;
		end else if (i_ce) begin
			ack_send_ff <= ack_now;
			if (ack_now)
				ack_kind_ff <= i_rx_error ? BLSC_ACK_NACK
					: busy_ff ? BLSC_ACK_BUSY : BLSC_ACK_IACK;
		end
	end

	// Repetition limits and counters
	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			blim_ff <= `BLSC_REP_RESET;
			nlim_ff <= `BLSC_REP_RESET;
			bcnt_ff <= 3'h0;
			ncnt_ff <= 3'h0;
		end else if (i_ce) begin
			if (host_rst) begin
				blim_ff <= `BLSC_REP_RESET;
				nlim_ff <= `BLSC_REP_RESET;
			end else if (i_set_rep_req) begin
				blim_ff <= i_set_rep_byte[`BLSC_REP_BUSY_HI:`BLSC_REP_BUSY_LO];
				nlim_ff <= i_set_rep_byte[`BLSC_REP_NACK_HI:`BLSC_REP_NACK_LO];
			end
			if (i_tx_start && tx_ff == BLSC_TX_IDLE) begin
				bcnt_ff <= blim_ff;
				ncnt_ff <= nlim_ff;
			end else if (retry_busy)
				bcnt_ff <= bcnt_ff - 3'h1;
			else if (retry_nack)
				ncnt_ff <= ncnt_ff - 3'h1;
		end
	end

	// Transmit sequencing: send, wait ack, idle gap, resend
	always_comb begin
		nxt_tx = tx_ff;
		case (tx_ff)
			BLSC_TX_IDLE: if (i_tx_start) nxt_tx = BLSC_TX_SEND;
			BLSC_TX_SEND: if (i_tx_done) nxt_tx = BLSC_TX_WAIT;
			BLSC_TX_WAIT: begin
				if (finish)
					nxt_tx = BLSC_TX_IDLE;
				else if (retry_busy || retry_nack)
					nxt_tx = BLSC_TX_GAP;
			end
			BLSC_TX_GAP: if (bit_tick && gap_ff >= gap_need_ff) nxt_tx = BLSC_TX_SEND;
			default: nxt_tx = BLSC_TX_IDLE;
		endcase
	end

	// Bit time and idle gap counting
	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			tx_ff <= BLSC_TX_IDLE;
			bit_ff <= 14'h0000;
			gap_ff <= 8'h00;
			gap_need_ff <= 8'h00;
			go_ff <= 1'b0;
		end else if (i_ce) begin
			tx_ff <= nxt_tx;
			go_ff <= (tx_ff != BLSC_TX_SEND) && (nxt_tx == BLSC_TX_SEND);
			bit_ff <= bit_tick ? `BLSC_BIT_CYCLES : bit_ff - 14'h0001;
			if (retry_busy)
				gap_need_ff <= 8'(`BLSC_BUSY_GAP_BITS);
			else if (retry_nack)
				gap_need_ff <= 8'(`BLSC_NACK_GAP_BITS);
			if (nxt_tx != tx_ff || (tx_ff == BLSC_TX_GAP && !i_bus_idle))
				gap_ff <= 8'h00; // Gap counts only continuous bus idle
			else if (bit_tick && gap_ff != 8'hFF)
				gap_ff <= gap_ff + 8'h01;
		end
	end

	// Outputs
	assign o_tx_go = go_ff;
	assign o_ack_send = ack_send_ff;
	assign o_ack_kind = ack_kind_ff;
	assign o_monitor_mode = mon_ff;
	assign o_auto_ack_flag = aa_ff;
	assign o_reject_mode = busy_ff;
	assign o_phys_addr = addr_ff;
	assign o_busy_limit = blim_ff;
	assign o_nack_limit = nlim_ff;

	// Checks
	a_busy_needs_aa: assert property (@(posedge i_clk) disable iff (i_reset)
		busy_ff |-> aa_ff) else $error("busy without auto-ack");
	a_ack_clears_busy: assert property (@(posedge i_clk) disable iff (i_reset)
		(i_ce && i_host_ack_req && !i_enter_reject_mode_request && !host_rst) |=> !busy_ff)
		else $error("ack did not clear busy");
	a_monitor_stays: assert property (@(posedge i_clk) disable iff (i_reset)
		(mon_ff && !host_rst) |=> mon_ff) else $error("monitor left early");
	a_aa_stays: assert property (@(posedge i_clk) disable iff (i_reset)
		(aa_ff && !host_rst) |=> aa_ff) else $error("auto-ack dropped");
	a_addr_waits_idle: assert property (@(posedge i_clk) disable iff (i_reset)
		$changed(addr_ff) |-> $past(i_bus_idle)) else $error("address applied busy");
	a_cfg_on_activate: assert property (@(posedge i_clk) disable iff (i_reset)
		$rose(aa_ff) |-> cfg_pend_ff) else $error("no config indication");
	a_nack_on_error: assert property (@(posedge i_clk) disable iff (i_reset)
		(ack_now && i_rx_error) |=> (o_ack_send && o_ack_kind == BLSC_ACK_NACK))
		else $error("error frame not nacked");
	a_limit_reset: assert property (@(posedge i_clk) disable iff (i_reset)
		$rose(host_rst) |=> (blim_ff == 3'h3 && nlim_ff == 3'h3))
		else $error("limits not three");
	a_state_low_bits: assert property (@(posedge i_clk) disable iff (i_reset)
		take_st |-> src_data == {sc_ff, re_ff, te_ff, pe_ff, tw_ff, 3'h7})
		else $error("state byte layout");
	a_flag_read_clear: assert property (@(posedge i_clk) disable iff (i_reset)
		(take_st && !i_poll_collision) |=> !sc_ff) else $error("flag kept after read");
	a_ack_filter: assert property (@(posedge i_clk) disable iff (i_reset)
		(take_rx && i_rx_is_ack) |-> mon_ff) else $error("ack forwarded");
endmodule

// file: blsc_consts.svh
// Constants of the bus link service control block: codes, fields, timings.
// Assumes inclusion by the package and the design modules only.
`ifndef BLSC_CONSTS_SVH
`define BLSC_CONSTS_SVH
`define BLSC_RESET_IND 8'h03
`define BLSC_STATE_LOW 3'h7
`define BLSC_CFG_IND_LOW 2'h1
`define BLSC_CON_LOW 7'h0B
`define BLSC_REP_RESET 3'h3
`define BLSC_REP_BUSY_HI 6
`define BLSC_REP_BUSY_LO 4
`define BLSC_REP_NACK_HI 2
`define BLSC_REP_NACK_LO 0
`define BLSC_BIT_NS 104167
`define BLSC_CLK_NS 10
`define BLSC_BUSY_GAP_BITS 8'h96
`define BLSC_NACK_GAP_BITS 8'h32
`define BLSC_ACK_WAIT_BITS 8'h1E
`define BLSC_BIT_CYCLES 14'h28B1
`endif

// file: blsc_pkg.sv
// Types of the bus link service control block.
// Assumes the constants header is available by bare name.
`include "blsc_consts.svh"
package blsc_pkg;
	typedef enum logic [1:0] {
		BLSC_ACK_IACK = 2'b00,
		BLSC_ACK_NACK = 2'b01,
		BLSC_ACK_BUSY = 2'b10,
		BLSC_ACK_NONE = 2'b11
	} blsc_ack_t;
	typedef enum logic [1:0] {
		BLSC_TX_IDLE = 2'b00,
		BLSC_TX_SEND = 2'b01,
		BLSC_TX_WAIT = 2'b10,
		BLSC_TX_GAP = 2'b11
	} blsc_tx_t;
endpackage

// file: blsc_buf2.sv
// Two-entry byte buffer between event sources and the host link.
// Assumes one clock, synchronous handshakes on both sides.
`timescale 1ns/1ps
module blsc_buf2 (
	// Clock, reset, enable
	input wire logic i_clk,
	input wire logic i_reset,
	input wire logic i_ce,
	// Fill side
	input wire logic i_valid,
	input wire logic [7:0] i_data,
	output logic o_ready,
	// Drain side
	output logic o_valid,
	output logic [7:0] o_data,
	input wire logic i_ready
);
	logic [7:0] mem_ff [2];
	logic rd_ff, wr_ff;
	logic [1:0] cnt_ff;
	wire push = i_ce && i_valid && (cnt_ff != 2'h2);
	wire pop = i_ce && i_ready && (cnt_ff != 2'h0);
	// Handshake flags from the fill count
	assign o_ready = (cnt_ff != 2'h2);
	assign o_valid = (cnt_ff != 2'h0);
	assign o_data = mem_ff[rd_ff];
	// Pointer and count update
	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			rd_ff <= 1'b0;
			wr_ff <= 1'b0;
			cnt_ff <= 2'h0;
		end else begin
			if (push)
				wr_ff <= ~wr_ff;
			if (pop)
				rd_ff <= ~rd_ff;
			cnt_ff <= cnt_ff + {1'b0, push} - {1'b0, pop};
		end
	end
	// Storage, no reset needed
	always_ff @(posedge i_clk) begin
		if (push)
			mem_ff[wr_ff] <= i_data;
	end
endmodule

// file: blsc_host_model.sv
// Host controller model: drains the host byte stream and keeps what it got.
// Assumes one clock; the bench asks for stalls through i_stall.
`timescale 1ns/1ps
module blsc_host_model (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_reset,
	// Byte stream from the device
	input wire logic i_valid,
	input wire logic [7:0] i_data,
	output logic o_ready,
	// Bench control
	input wire logic i_stall
);
	logic [7:0] got_q[$];
	// Ready follows the stall request one edge late, like a slow host
	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			o_ready <= 1'b0;
		end else begin
			o_ready <= !i_stall;
			if (i_valid && o_ready) begin
				got_q.push_back(i_data);
			end
		end
	end
endmodule

// file: bus_link_service_control_tb.sv
// Testbench of the host service control: row loop, then hand-written cases.
// Assumes the host model file and the design package are compiled first.
`timescale 1ns/1ps
module bus_link_service_control_tb;
	import blsc_pkg::*;
	typedef struct packed {logic [7:0] d; logic a; logic f;} blsc_row_t;
	logic i_clk = 1'b0, i_reset = 1'b1, i_ce = 1'b1, i_stall = 1'b0, i_host_ready;
	logic i_host_reset_req = 1'b0, i_enter_normal = 1'b0, i_enter_reject_mode_request = 1'b0;
	logic i_leave_reject_mode_request = 1'b0, i_host_ack_req = 1'b0, i_monitor_req = 1'b0;
	logic i_set_addr_req = 1'b0, i_set_rep_req = 1'b0, i_state_req = 1'b0, i_crc_on = 1'b1;
	logic i_auto_poll_on = 1'b0, i_marker_on = 1'b0, i_poll_collision = 1'b0;
	logic i_thermal_warn = 1'b0, i_host_byte_bad = 1'b0, i_cmd_order_bad = 1'b0;
	logic i_rx_valid = 1'b0, i_rx_is_ack = 1'b0, i_bus_idle = 1'b0, i_rx_dest_hit = 1'b0;
	logic i_rx_dest_group = 1'b0, i_rx_error = 1'b0, i_rx_frame_end = 1'b0, i_tx_start = 1'b0;
	logic i_tx_done = 1'b0, i_tx_drive_zero = 1'b0, i_tx_read_bit = 1'b0, i_ack_valid = 1'b0;
	logic [15:0] i_set_addr = 16'h0000, i_rx_dest = 16'h0000, o_phys_addr;
	logic [7:0] i_set_rep_byte = 8'h00, i_rx_data = 8'h00, o_host_data;
	logic [1:0] i_ack_kind = 2'h0, o_ack_kind;
	logic o_tx_go, o_ack_send, o_host_valid, o_monitor_mode, o_auto_ack_flag, o_reject_mode;
	logic [2:0] o_busy_limit, o_nack_limit;
	int n_errors = 0;
	int n_compared = 0;
	blsc_row_t rows [5] = '{{8'hBC, 1'b0, 1'b1}, {8'h00, 1'b0, 1'b1}, {8'hFF, 1'b0, 1'b1},
		{8'hCC, 1'b1, 1'b0}, {8'h0C, 1'b1, 1'b0}};

	blsc_top blsc_top_i (.i_clk, .i_reset, .i_ce, .i_host_reset_req, .i_enter_normal,
		.i_enter_reject_mode_request, .i_leave_reject_mode_request, .i_host_ack_req,
		.i_monitor_req, .i_set_addr_req, .i_set_addr, .i_set_rep_req, .i_set_rep_byte,
		.i_state_req, .i_auto_poll_on, .i_crc_on, .i_marker_on, .i_poll_collision,
		.i_thermal_warn, .i_host_byte_bad, .i_cmd_order_bad, .i_rx_valid, .i_rx_data,
		.i_rx_is_ack, .i_bus_idle, .i_rx_dest_hit, .i_rx_dest, .i_rx_dest_group, .i_rx_error,
		.i_rx_frame_end, .i_tx_start, .i_tx_done, .i_tx_drive_zero, .i_tx_read_bit,
		.i_ack_valid, .i_ack_kind, .o_tx_go, .o_ack_send, .o_ack_kind, .o_host_valid,
		.o_host_data, .i_host_ready, .o_monitor_mode, .o_auto_ack_flag, .o_reject_mode,
		.o_phys_addr, .o_busy_limit, .o_nack_limit);
	blsc_host_model blsc_host_model_i (.i_clk(i_clk), .i_reset(i_reset),
		.i_valid(o_host_valid), .i_data(o_host_data), .o_ready(i_host_ready),
		.i_stall(i_stall));

	// Clock of 100 MHz
	always #5 i_clk = ~i_clk;

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_errors++;
			$display("[ERR] t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge i_clk);
	endtask
	// Waits a bounded time for the next byte at the host
	task automatic got(input logic [7:0] exp);
		int k = 0;
		while (blsc_host_model_i.got_q.size() == 0 && k < 50) begin
			tick(1);
			k++;
		end
		if (blsc_host_model_i.got_q.size() == 0) begin
			chk(16'hFFFF, {8'h00, exp});
		end else begin
			chk({8'h00, blsc_host_model_i.got_q.pop_front()}, {8'h00, exp});
		end
	endtask
	// One received bus byte
	task automatic rxb(input logic [7:0] d, input logic a);
		tick(1);
		i_rx_valid <= 1'b1;
		i_rx_data <= d;
		i_rx_is_ack <= a;
		tick(1);
		i_rx_valid <= 1'b0;
	endtask
	// One frame end; exp is {ack sent, ack kind}
	task automatic frame(input logic [15:0] d, input logic g, input logic e,
		input logic [2:0] exp);
		tick(1);
		i_rx_frame_end <= 1'b1;
		i_rx_dest_hit <= 1'b1;
		i_rx_dest <= d;
		i_rx_dest_group <= g;
		i_rx_error <= e;
		tick(1);
		i_rx_frame_end <= 1'b0;
		#1 chk({13'h0000, o_ack_send, o_ack_kind}, {13'h0000, exp});
	endtask
	// One send answered by an acknowledge of kind k
	task automatic send(input logic [1:0] k);
		tick(1);
		i_tx_start <= 1'b1;
		tick(1);
		{i_tx_start, i_tx_done} <= 2'b01;
		tick(1);
		{i_tx_done, i_ack_valid, i_ack_kind} <= {2'b01, k};
		tick(1);
		i_ack_valid <= 1'b0;
	endtask
	task automatic end_of_test();
		if (n_errors == 0 && n_compared > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	// Watchdog against hangs
	initial begin
		#300000;
		n_errors++;
		end_of_test();
	end

	initial begin
		tick(16);
		i_reset <= 1'b0;
		#1 chk(o_busy_limit, 3'h3);
		chk(o_nack_limit, 3'h3);
		tick(1);
		i_enter_normal <= 1'b1;
		tick(1);
		i_enter_normal <= 1'b0;
		got(8'h03);
		// Ordinary bus bytes: data passes, acknowledge bytes are dropped
		foreach (rows[r]) begin
			rxb(rows[r].d, rows[r].a);
			tick(4);
			if (rows[r].f) got(rows[r].d);
			else chk(blsc_host_model_i.got_q.size(), 16'h0000);
		end
		// All error events except the transmit error at once, then the state byte twice
		i_poll_collision <= 1'b1;
		i_thermal_warn <= 1'b1;
		i_host_byte_bad <= 1'b1;
		i_cmd_order_bad <= 1'b1;
		tick(1);
		{i_poll_collision, i_thermal_warn, i_host_byte_bad, i_cmd_order_bad} <= 4'h0;
		i_state_req <= 1'b1;
		tick(1);
		i_state_req <= 1'b0;
		got(8'hDF);
		i_state_req <= 1'b1;
		tick(1);
		i_state_req <= 1'b0;
		got(8'h07);
		// Reject mode without auto-ack is ignored
		i_enter_reject_mode_request <= 1'b1;
		tick(1);
		i_enter_reject_mode_request <= 1'b0;
		#1 chk(o_reject_mode, 1'b0);
		// Address taken while the bus is busy waits for idle
		tick(1);
		i_set_addr_req <= 1'b1;
		i_set_addr <= 16'h1203;
		tick(1);
		i_set_addr_req <= 1'b0;
		tick(4);
		#1 chk(o_auto_ack_flag, 1'b0);
		tick(1);
		i_bus_idle <= 1'b1;
		tick(3);
		#1 chk(o_auto_ack_flag, 1'b1);
		chk(o_phys_addr, 16'h1203);
		got(8'h29);
		frame(16'h1203, 1'b0, 1'b0, {1'b1, BLSC_ACK_IACK});
		frame(16'h7777, 1'b1, 1'b0, {1'b1, BLSC_ACK_IACK});
		frame(16'h1204, 1'b0, 1'b0, {1'b0, BLSC_ACK_IACK});
		frame(16'h1203, 1'b0, 1'b1, {1'b1, BLSC_ACK_NACK});
		// Reject mode, cleared by the host acknowledge and by the leave request
		tick(1);
		i_enter_reject_mode_request <= 1'b1;
		tick(1);
		i_enter_reject_mode_request <= 1'b0;
		#1 chk(o_reject_mode, 1'b1);
		frame(16'h1203, 1'b0, 1'b0, {1'b1, BLSC_ACK_BUSY});
		tick(1);
		i_host_ack_req <= 1'b1;
		tick(1);
		i_host_ack_req <= 1'b0;
		frame(16'h1203, 1'b0, 1'b0, {1'b1, BLSC_ACK_IACK});
		tick(1);
		i_enter_reject_mode_request <= 1'b1;
		tick(1);
		i_enter_reject_mode_request <= 1'b0;
		i_leave_reject_mode_request <= 1'b1;
		tick(1);
		i_leave_reject_mode_request <= 1'b0;
		frame(16'h1203, 1'b0, 1'b0, {1'b1, BLSC_ACK_IACK});
		// Second address only moves the address
		tick(1);
		i_set_addr_req <= 1'b1;
		i_set_addr <= 16'h0455;
		tick(1);
		i_set_addr_req <= 1'b0;
		tick(6);
		#1 chk(o_phys_addr, 16'h0455);
		chk(blsc_host_model_i.got_q.size(), 16'h0000);
		// Repeat limits; bits 3 and 7 kept zero
		tick(1);
		i_set_rep_req <= 1'b1;
		i_set_rep_byte <= 8'h25;
		tick(1);
		i_set_rep_req <= 1'b0;
		tick(1);
		#1 chk({o_busy_limit, o_nack_limit}, 6'h15);
		// Clock enable low freezes the block, so this request is lost
		tick(1);
		{i_ce, i_set_rep_req, i_set_rep_byte} <= 10'h177;
		tick(1);
		{i_ce, i_set_rep_req} <= 2'b10;
		tick(1);
		#1 chk({o_busy_limit, o_nack_limit}, 6'h15);
		// A send with a read-back mismatch, answered IACK
		tick(1);
		i_tx_start <= 1'b1;
		tick(1);
		i_tx_start <= 1'b0;
		#1 chk(o_tx_go, 1'b1);
		tick(1);
		{i_tx_drive_zero, i_tx_read_bit} <= 2'h3;
		tick(1);
		{i_tx_drive_zero, i_tx_read_bit, i_tx_done} <= 3'h1;
		tick(1);
		{i_tx_done, i_ack_valid, i_ack_kind} <= {2'b01, BLSC_ACK_IACK};
		tick(1);
		i_ack_valid <= 1'b0;
		got(8'h8B);
		i_state_req <= 1'b1;
		tick(1);
		i_state_req <= 1'b0;
		got(8'h27);
		// Limits of zero: BUSY, NACK or an invalid answer ends the send negative
		tick(1);
		{i_set_rep_req, i_set_rep_byte} <= 9'h100;
		tick(1);
		i_set_rep_req <= 1'b0;
		send(BLSC_ACK_BUSY);
		got(8'h0B);
		send(BLSC_ACK_NACK);
		got(8'h0B);
		send(BLSC_ACK_NONE);
		got(8'h0B);
		// One BUSY retry left: no confirmation, and no resend in the first five cycles of the idle gap
		tick(1);
		{i_set_rep_req, i_set_rep_byte} <= 9'h110;
		tick(1);
		i_set_rep_req <= 1'b0;
		send(BLSC_ACK_BUSY);
		repeat (5) begin
			#1 chk(o_tx_go, 1'b0);
			tick(1);
		end
		chk(blsc_host_model_i.got_q.size(), 16'h0000);
		// Host stalls; two bytes sent two cycles apart wait in the buffer
		i_stall <= 1'b1;
		tick(2);
		rxb(8'hA1, 1'b0);
		rxb(8'hA2, 1'b0);
		tick(4);
		#1 chk(o_host_valid, 1'b1);
		chk(blsc_host_model_i.got_q.size(), 16'h0000);
		tick(1);
		i_stall <= 1'b0;
		got(8'hA1);
		got(8'hA2);
		// Monitor mode passes acks and leaves only by host reset
		tick(1);
		i_monitor_req <= 1'b1;
		tick(1);
		i_monitor_req <= 1'b0;
		rxb(8'hCC, 1'b1);
		got(8'hCC);
		i_host_ack_req <= 1'b1;
		tick(1);
		i_host_ack_req <= 1'b0;
		#1 chk(o_monitor_mode, 1'b1);
		tick(1);
		i_host_reset_req <= 1'b1;
		tick(1);
		i_host_reset_req <= 1'b0;
		tick(1);
		#1 chk(o_monitor_mode, 1'b0);
		chk(o_auto_ack_flag, 1'b0);
		chk({o_busy_limit, o_nack_limit}, 6'h1B);
		// Mid-run reset clears the state; Normal is announced again after it
		i_reset <= 1'b1;
		tick(2);
		#1 chk(o_phys_addr, 16'h0000);
		chk({13'h0000, o_host_valid, o_tx_go, o_ack_send}, 16'h0000);
		chk({o_busy_limit, o_nack_limit}, 6'h1B);
		tick(1);
		i_reset <= 1'b0;
		tick(1);
		i_enter_normal <= 1'b1;
		tick(1);
		i_enter_normal <= 1'b0;
		got(8'h03);
		end_of_test();
	end
endmodule
